//--- src/sim_monitor.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module sim_monitor #(
  parameter int TICK_CYCLES = sim_pkg::TICK_CYCLES,
  parameter int LIMIT_W = 16
) (
  input wire logic i_clk, // 200 MHz clock
  input wire logic i_resetn, // sync reset, active low
  input wire sim_pkg::sim_bus_t i_bus, // register request
  output logic [31:0] o_rdata, // read data, cycle after strobe
  output logic o_irq, // level interrupt
  input wire logic i_single_contact, // single contact closed
  input wire logic i_single_fault, // single contact wiring fault
  input wire logic i_static_sig, // static signal at supply level
  input wire logic [1:0] i_dep_contact, // dependent pair, closed
  input wire logic [1:0] i_dep_fault, // dependent pair faults
  input wire logic [1:0] i_ind_contact, // independent pair, closed
  input wire logic [1:0] i_ind_fault, // independent pair faults
  input wire logic [7:0] i_sel_in, // selector positions
  input wire logic i_sel_fault, // selector wiring fault
  output sim_pkg::sim_out_t o_out // monitor results
);

  // ==========================================================
  // functions
  // count of set bits
  function automatic logic [3:0] sim_ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < 8; k++) begin
      n = n + {3'h0, v[k]};
    end
    return n;
  endfunction

  // position number of the highest set bit, 1 based
  function automatic logic [3:0] sim_pos(input logic [7:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int k = 0; k < 8; k++) begin
      if (v[k]) begin
        p = 4'(k + 1);
      end
    end
    return p;
  endfunction

  // normalise a pair: 1 means the contact is in its safe state
  function automatic logic [1:0] sim_norm(input logic [1:0] c, input logic arr);
    return {c[1], c[0] ^ arr};
  endfunction

  // ==========================================================
  // registers
  logic dep_arr_q;
  logic ind_arr_q;
  logic [3:0] pos_cnt_q;
  logic [LIMIT_W-1:0] limit_q;
  logic [sim_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sim_pkg::IRQ_W-1:0] irq_en_q;
  logic [sim_pkg::IRQ_W-1:0] err_prev_q;
  logic [31:0] rdata_q;
  logic module_err_q;
  logic [$clog2(TICK_CYCLES+1)-1:0] presc_q;
  logic [LIMIT_W-1:0] gap_q;
  sim_pkg::sim_dep_state_t dep_state_q;
  sim_pkg::sim_dep_state_t dep_state_d;
  sim_pkg::sim_out_t out_q;
  sim_pkg::sim_out_t out_d;

  // ==========================================================
  // bus decode
  wire wr_ctrl = i_bus.wr && (i_bus.addr == sim_pkg::ADDR_CTRL);
  wire wr_limit = i_bus.wr && (i_bus.addr == sim_pkg::ADDR_LIMIT);
  wire wr_en = i_bus.wr && (i_bus.addr == sim_pkg::ADDR_IRQ_EN);
  wire wr_clr = i_bus.wr && (i_bus.addr == sim_pkg::ADDR_IRQ_CLR);
  wire [3:0] pos_wr = i_bus.wdata[sim_pkg::CTRL_POS_MSB:sim_pkg::CTRL_POS_LSB];
  // clamp the requested position count
  wire [3:0] pos_clamped = (pos_wr < sim_pkg::POS_MIN) ? sim_pkg::POS_MIN :
                           (pos_wr > sim_pkg::POS_MAX) ? sim_pkg::POS_MAX : pos_wr;

  // ==========================================================
  // prescaler tick for simultaneity timing
  wire tick = (presc_q == ($bits(presc_q))'(TICK_CYCLES - 1));

  // ==========================================================
  // input evaluation
  wire [1:0] dep_norm = sim_norm(i_dep_contact, dep_arr_q);
  wire [1:0] ind_norm = sim_norm(i_ind_contact, ind_arr_q);
  wire dep_split = dep_norm[0] ^ dep_norm[1];
  wire gap_over = (gap_q >= limit_q);
  // only the configured number of selector inputs count
  wire [7:0] sel_mask = 8'((9'h001 << pos_cnt_q) - 9'h001);
  wire [7:0] sel_live = i_sel_in & sel_mask;
  wire sel_ok = (sim_ones(sel_live) == 4'h1) && !i_sel_fault;
  wire single_err = i_single_fault;
  wire dep_err = (|i_dep_fault) || (dep_state_d == sim_pkg::SIM_FAIL);
  wire ind_err = |i_ind_fault;
  wire sel_err = !sel_ok;
  wire any_err = single_err | dep_err | ind_err | sel_err;
  wire err_now = module_err_q | any_err;
  wire [sim_pkg::IRQ_W-1:0] err_vec = {err_now, sel_err, ind_err, dep_err, single_err};
  wire [sim_pkg::IRQ_W-1:0] err_rise = err_vec & ~err_prev_q;

  // ==========================================================
  // dependent pair window state
  always_comb begin
    dep_state_d = dep_state_q;
    case (dep_state_q)
      sim_pkg::SIM_SYNC: begin
        if (dep_split) begin
          dep_state_d = sim_pkg::SIM_WAIT;
        end
      end
      sim_pkg::SIM_WAIT: begin
        if (!dep_split) begin
          dep_state_d = sim_pkg::SIM_SYNC;
        end else if (gap_over) begin
          dep_state_d = sim_pkg::SIM_FAIL;
        end
      end
      sim_pkg::SIM_FAIL: begin
        if (dep_norm == 2'h0) begin
          dep_state_d = sim_pkg::SIM_SYNC;
        end
      end
      default: begin
        dep_state_d = sim_pkg::SIM_FAIL;
      end
    endcase
  end

  // ==========================================================
  // next output values, forced open in error state
  always_comb begin
    out_d = '0;
    out_d.module_err = err_now;
    out_d.single_err = single_err;
    out_d.dep_err = dep_err;
    out_d.ind_err = ind_err;
    out_d.sel_err = sel_err;
    if (!err_now) begin
      out_d.single_active = i_single_contact;
      out_d.static_active = i_static_sig;
      out_d.dep_active = (dep_norm == 2'h3) && (dep_state_d == sim_pkg::SIM_SYNC);
      out_d.ind_active = (ind_norm == 2'h3);
      out_d.sel_pos = sim_pos(sel_live);
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dep_arr_q <= 1'b0;
      ind_arr_q <= 1'b0;
      pos_cnt_q <= sim_pkg::POS_RESET;
      limit_q <= LIMIT_W'(sim_pkg::LIMIT_RESET);
      irq_en_q <= '0;
    end else begin
      if (wr_ctrl) begin
        dep_arr_q <= i_bus.wdata[sim_pkg::CTRL_DEP_ARR_BIT];
        ind_arr_q <= i_bus.wdata[sim_pkg::CTRL_IND_ARR_BIT];
        pos_cnt_q <= pos_clamped;
      end
      if (wr_limit) begin
        limit_q <= i_bus.wdata[LIMIT_W-1:0];
      end
      if (wr_en) begin
        irq_en_q <= i_bus.wdata[sim_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupt status, set wins over clear
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_stat_q <= '0;
      err_prev_q <= '0;
    end else begin
      err_prev_q <= err_vec;
      irq_stat_q <= (irq_stat_q & ~({sim_pkg::IRQ_W{wr_clr}} &
                     i_bus.wdata[sim_pkg::IRQ_W-1:0])) | err_rise;
    end
  end

  // ==========================================================
  // prescaler and gap counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      presc_q <= '0;
      gap_q <= '0;
    end else begin
      presc_q <= (tick || dep_state_q != sim_pkg::SIM_WAIT) ? '0 : presc_q + 1'b1;
      if (dep_state_q != sim_pkg::SIM_WAIT) begin
        gap_q <= '0;
      end else if (tick && !gap_over) begin
        gap_q <= gap_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // state and outputs
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      dep_state_q <= sim_pkg::SIM_SYNC;
      module_err_q <= 1'b0;
      out_q <= '0;
    end else begin
      dep_state_q <= dep_state_d;
      module_err_q <= err_now;
      out_q <= out_d;
    end
  end

  // ==========================================================
  // read data, one cycle after the strobe
  wire [31:0] cfg_word = {24'h0, pos_cnt_q, 2'h0, ind_arr_q, dep_arr_q};
  wire [31:0] rd_mux =
    (i_bus.addr == sim_pkg::ADDR_CTRL) ? cfg_word :
    (i_bus.addr == sim_pkg::ADDR_LIMIT) ? 32'(limit_q) :
    (i_bus.addr == sim_pkg::ADDR_STATE) ? 32'(out_q) :
    (i_bus.addr == sim_pkg::ADDR_IRQ_STAT) ? 32'(irq_stat_q) :
    (i_bus.addr == sim_pkg::ADDR_IRQ_EN) ? 32'(irq_en_q) : 32'h0;

  // read register, zero outside read cycles
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= i_bus.rd ? rd_mux : 32'h0;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = |(irq_stat_q & irq_en_q);
  assign o_out = out_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_SINGLE_ACTIVE: assert property (
    o_out.single_active |-> $past(i_single_contact) && !$past(i_single_fault))
    else $error("single output active without closed clean contact");

  AST_SINGLE_ERR: assert property (
    $rose(i_single_fault) |=> o_out.single_err && !o_out.single_active)
    else $error("single fault not flagged");

  AST_STATIC_OFF: assert property (
    !i_static_sig |=> !o_out.static_active)
    else $error("static output active without input");

  AST_DUAL_SAFE: assert property (
    o_out.dep_active || o_out.ind_active |-> !o_out.module_err &&
    (!o_out.dep_active || $past(dep_norm) == 2'h3) &&
    (!o_out.ind_active || $past(ind_norm) == 2'h3))
    else $error("dual output active outside safe state");

  AST_GAP_FAIL: assert property (
    dep_state_q == sim_pkg::SIM_WAIT && dep_split && gap_over |=> o_out.dep_err
    && dep_state_q == sim_pkg::SIM_FAIL)
    else $error("missed simultaneity not flagged");

  AST_GAP_COUNT: assert property (
    dep_state_q == sim_pkg::SIM_WAIT && tick && !gap_over && dep_split
    |=> gap_q == $past(gap_q) + 1'b1)
    else $error("gap counter did not advance on tick");

  AST_IND_ERR: assert property (
    ##1 o_out.ind_err == $past(|i_ind_fault))
    else $error("independent error not tied to faults");

  AST_SEL_ZERO: assert property (
    o_out.sel_err || o_out.module_err |-> o_out.sel_pos == 4'h0)
    else $error("selector value nonzero in error");

  AST_SEL_ERR: assert property (
    !sel_ok |=> o_out.sel_err && o_out.module_err)
    else $error("bad selector state not flagged");

  AST_POS_RANGE: assert property (
    pos_cnt_q >= sim_pkg::POS_MIN && pos_cnt_q <= sim_pkg::POS_MAX)
    else $error("position count out of range");

  AST_ERR_OPEN: assert property (
    module_err_q |=> o_out.module_err && !o_out.single_active && !o_out.static_active
    && !o_out.dep_active && !o_out.ind_active)
    else $error("outputs not open in error state");

  COV_DEP_ACTIVE: cover property (o_out.dep_active);
  COV_DEP_FAIL: cover property (dep_state_q == sim_pkg::SIM_FAIL);
  COV_SEL_POS: cover property (o_out.sel_pos == 4'h3);
  COV_IRQ: cover property (o_irq);

endmodule

//--- common/sim_pkg.sv
package sim_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h14;

  // ==========================================================
  // control field positions and reset values
  localparam int CTRL_DEP_ARR_BIT = 0;
  localparam int CTRL_IND_ARR_BIT = 1;
  localparam int CTRL_POS_LSB = 4;
  localparam int CTRL_POS_MSB = 7;
  localparam logic [3:0] POS_MIN = 4'h2;
  localparam logic [3:0] POS_MAX = 4'h8;
  localparam logic [3:0] POS_RESET = 4'h8;
  localparam logic [15:0] LIMIT_RESET = 16'h03E8;
  localparam int IRQ_W = 5;
  localparam int STATE_W = 13;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SIM_SYNC = 2'b00,
    SIM_WAIT = 2'b01,
    SIM_FAIL = 2'b11
  } sim_dep_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sim_bus_t;

  typedef struct packed {
    logic module_err;
    logic [3:0] sel_pos;
    logic sel_err;
    logic ind_err;
    logic ind_active;
    logic dep_err;
    logic dep_active;
    logic static_active;
    logic single_err;
    logic single_active;
  } sim_out_t;

endpackage

//--- tb/sim_field.sv
`timescale 1ns/10ps
// ==========================================================
// dual contact field device, second contact trails the first
module sim_field (
  input wire logic i_clk, // bench clock
  input wire logic i_cmd, // 1 = both contacts in safe state
  input wire logic i_nono, // 1 = contact 0 is normally open
  input wire logic [5:0] i_lag, // cycles contact 1 trails contact 0
  output logic [1:0] o_contact // raw contact levels
);
  logic [63:0] hist_q;

  // history of the commanded state
  always_ff @(posedge i_clk) begin
    hist_q <= {hist_q[62:0], i_cmd};
  end

  // contact 0 moves at once, contact 1 after the lag
  assign o_contact[0] = i_cmd ^ i_nono;
  assign o_contact[1] = (i_lag == 6'h00) ? i_cmd : hist_q[i_lag - 6'h01];
endmodule

//--- tb/sim_monitor_tb.sv
`timescale 1ns/10ps
module sim_monitor_tb;
  logic i_clk = 1'b0;
  logic i_resetn;
  sim_pkg::sim_bus_t i_bus;
  logic [31:0] o_rdata;
  logic o_irq;
  logic sc, sf, st, cmd, nono, sfl, ia, rd_seen;
  logic [5:0] lag;
  logic [1:0] dc, df, ic, ifl;
  logic [7:0] sel;
  sim_pkg::sim_out_t o_out, w;
  logic [31:0] q[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'hB869B243;
  int p, r, k;

  sim_monitor #(.TICK_CYCLES(10)) sim_monitor_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq), .i_single_contact(sc),
    .i_single_fault(sf), .i_static_sig(st), .i_dep_contact(dc), .i_dep_fault(df),
    .i_ind_contact(ic), .i_ind_fault(ifl), .i_sel_in(sel), .i_sel_fault(sfl),
    .o_out(o_out));
  sim_field sim_field_i (.i_clk(i_clk), .i_cmd(cmd), .i_nono(nono), .i_lag(lag),
    .o_contact(dc));

  // ==========================================================
  // clock and shared tasks
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one bus cycle; a read queues its expected data
  task automatic op(input logic wr, input logic rd, input logic [7:0] a, input logic [31:0] d);
    i_bus <= {a, d, wr, rd};
    if (rd) q.push_back(d);
    @(posedge i_clk);
  endtask

  task automatic tick(input int n);
    i_bus <= '0;
    repeat (n) @(posedge i_clk);
  endtask

  // reset with every field input safe and one selector position on
  task automatic rst(input logic arr);
    i_resetn <= 1'b0;
    {sc, sf, st, cmd, nono, lag, df, ic, ifl, sel, sfl} <=
      {1'b1, 1'b0, 1'b1, 1'b1, arr, 6'h00, 2'h0, 2'h3, 2'h0, 8'h01, 1'b0};
    tick(2);
    i_resetn <= 1'b1;
    tick(1);
  endtask

  // ==========================================================
  // read data watcher, compares against the oldest note
  initial rd_seen = 1'b0;
  always @(posedge i_clk) begin
    if (rd_seen) check(o_rdata, q.pop_front());
    rd_seen <= i_bus.rd;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    n_mismatch++;
    results();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst(1'b0);
    // reset values, read-only and unmapped places, count clamp
    op(1'b1, 1'b0, sim_pkg::ADDR_STATE, 32'hFFFFFFFF);
    op(1'b0, 1'b1, sim_pkg::ADDR_CTRL, 32'h80);
    op(1'b0, 1'b1, sim_pkg::ADDR_LIMIT, 32'h3E8);
    op(1'b0, 1'b1, 8'h18, 32'h0);
    op(1'b0, 1'b1, sim_pkg::ADDR_IRQ_EN, 32'h0);
    op(1'b1, 1'b0, sim_pkg::ADDR_CTRL, 32'h10);
    op(1'b0, 1'b1, sim_pkg::ADDR_CTRL, 32'h20);
    op(1'b1, 1'b0, sim_pkg::ADDR_CTRL, 32'hF0);
    op(1'b0, 1'b1, sim_pkg::ADDR_CTRL, 32'h80);
    // random healthy traffic, both arrangements, random count
    for (k = 0; k < 2; k++) begin
      rst(k[0]);
      p = 2 + {$random(seed)} % 7;
      op(1'b1, 1'b0, sim_pkg::ADDR_CTRL, (p << 4) | (k * 3));
      repeat (16) begin
        r = $random(seed);
        {sc, st, cmd, ic} <= r[4:0];
        sel <= (r[15:8] & (8'hFF << p)) | (8'h01 << (r[23:16] % p));
        tick(3);
        ia = k ? (r[1:0] == 2'b10) : (r[1:0] == 2'b11);
        w = '{1'b0, 4'(r[23:16] % p + 1), 1'b0, 1'b0, ia, 1'b0, r[2], r[3], 1'b0, r[4]};
        op(1'b0, 1'b1, sim_pkg::ADDR_STATE, 32'(w));
      end
    end
    // each fault kind: latched error, outputs open, interrupt set and cleared
    for (k = 0; k < 6; k++) begin
      rst(1'b0);
      op(1'b1, 1'b0, sim_pkg::ADDR_IRQ_EN, k ? 32'h1F : 32'h0);
      case (k)
        0: sf <= 1'b1;
        1: df <= 2'h1;
        2: ifl <= 2'h2;
        3: sfl <= 1'b1;
        4: sel <= 8'h00;
        default: sel <= 8'h03;
      endcase
      tick(3);
      w = '{1'b1, 4'h0, k > 2, k == 2, 1'b0, k == 1, 1'b0, 1'b0, k == 0, 1'b0};
      op(1'b0, 1'b1, sim_pkg::ADDR_STATE, 32'(w));
      op(1'b0, 1'b1, sim_pkg::ADDR_IRQ_STAT, 32'h10 | (32'h1 << ((k > 2) ? 3 : k)));
      check({31'h0, o_irq}, {31'h0, k != 0});
      {sf, df, ifl, sfl, sel} <= {1'b0, 2'h0, 2'h0, 1'b0, 8'h01};
      op(1'b1, 1'b0, sim_pkg::ADDR_IRQ_CLR, 32'h1F);
      tick(3);
      w = '0;
      w.module_err = 1'b1;
      op(1'b0, 1'b1, sim_pkg::ADDR_STATE, 32'(w));
      op(1'b0, 1'b1, sim_pkg::ADDR_IRQ_STAT, 32'h0);
      check({31'h0, o_irq}, 32'h0);
    end
    // dependent pair: follow inside the window, then miss it
    rst(1'b0);
    op(1'b1, 1'b0, sim_pkg::ADDR_LIMIT, 32'h3);
    lag <= 6'd18;
    cmd <= 1'b0;
    tick(30);
    w = '{1'b0, 4'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    op(1'b0, 1'b1, sim_pkg::ADDR_STATE, 32'(w));
    tick(64);
    lag <= 6'd60;
    cmd <= 1'b1;
    tick(45);
    w = '{1'b1, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    op(1'b0, 1'b1, sim_pkg::ADDR_STATE, 32'(w));
    tick(3);
    results();
  end
endmodule
